// [hdl/rxagc_pkg.sv]
// rxagc_pkg: shared constants, types and register map of the receive
// gain-control and carrier-sense sequencer.
// assumes a 32-bit AHB-Lite slave port with byte addresses below 0x100.
package rxagc_pkg;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_MAIN   = 8'h00;
   localparam logic [7:0] ADDR_SEQ    = 8'h04;
   localparam logic [7:0] ADDR_IFACE  = 8'h08;
   localparam logic [7:0] ADDR_TIMING = 8'h0C;
   localparam logic [7:0] ADDR_AVG    = 8'h10;
   localparam logic [7:0] ADDR_LIMIT  = 8'h14;
   localparam logic [7:0] ADDR_LEVEL  = 8'h18;
   localparam logic [7:0] ADDR_DEMOD  = 8'h1C;
   localparam logic [7:0] ADDR_MUX    = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_AFC    = 8'h28;
   localparam logic [7:0] ADDR_INST   = 8'h2C;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int MAIN_SLEEP_BIT = 0;
   localparam int MAIN_CAL_LSB   = 2;
   localparam int MAIN_PD_LSB    = 4;
   localparam int MAIN_RXEN_BIT  = 6;
   localparam int SEQ_RXW_LSB    = 0;
   localparam int SEQ_CSW_LSB    = 3;
   localparam int SEQ_SEL_BIT    = 7;
   localparam int TIM_FRZ_LSB    = 0;
   localparam int TIM_WAIT_LSB   = 2;
   localparam int LIM_MAX_LSB    = 0;
   localparam int LIM_DN_LSB     = 5;
   localparam int LVL_CS_LSB     = 0;
   localparam int LVL_UP_LSB     = 5;
   localparam int LVL_SET_BIT    = 8;
   localparam int STAT_CS_BIT    = 3;
   localparam int STAT_GAIN_LSB  = 4;
   localparam int STAT_SLEEP_BIT = 9;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [6:0] MAIN_RST   = 7'h00;
   localparam logic [7:0] SEQ_RST    = 8'h00;
   localparam logic [4:0] TIM_RST    = 5'h00;
   localparam logic [1:0] AVG_RST    = 2'h0;
   localparam logic [7:0] LIM_RST    = 8'h0F;
   localparam logic [8:0] LVL_RST    = 9'h000;
   localparam logic [2:0] DEMOD_RST  = 3'h0;
   localparam logic [3:0] MUX_RST    = 4'h0;

   // ****************************************************************
   // counts and codes
   // ****************************************************************
   localparam logic [7:0] FREEZE_BASE = 8'h10;
   localparam logic [7:0] SETTLE_BASE = 8'h10;
   localparam logic [7:0] SETTLE_MAX  = 8'h30;
   localparam logic [7:0] AVG_BASE    = 8'h02;
   localparam logic [8:0] CS_MARGIN   = 9'h008;
   localparam logic [8:0] DN_HYST     = 9'h003;
   localparam logic [3:0] SEQ_UNIT_M1 = 4'hF;
   localparam logic [1:0] PD_SEQUENCE = 2'h3;
   localparam logic [3:0] MUX_CS      = 4'h4;
   localparam logic [3:0] MUX_MCLK    = 4'hD;
   localparam logic [1:0] CAL_ALWAYS  = 2'h0;
   localparam logic [1:0] CAL_EVERY16 = 2'h1;
   localparam logic [1:0] CAL_EVR256  = 2'h2;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [3:0] {
      AG_OFF    = 4'b0001,
      AG_FREEZE = 4'b0010,
      AG_SETTLE = 4'b0100,
      AG_MEAS   = 4'b1000
   } rxagc_agc_st_t;

   typedef enum logic [5:0] {
      SQ_OFF   = 6'b000001,
      SQ_SLEEP = 6'b000010,
      SQ_CAL   = 6'b000100,
      SQ_RXW   = 6'b001000,
      SQ_CSW   = 6'b010000,
      SQ_RX    = 6'b100000
   } rxagc_seq_st_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic       valid;
   } rxagc_req_t;

endpackage

// [hdl/rxagc_top.sv]
// rxagc_top: receive gain-control loop, carrier sense, power-up
// sequencer and frequency read-back, behind an AHB-Lite slave.
// assumes tick inputs are one-cycle pulses synchronous to i_core_clk;
// the core clock serves as the reference for the adc clock divider.
// Behaviour
// RL1: gain loop holds 16..128 adc clocks first
// RL2: wait 16..48 filter clocks before each measure; here only after the freeze and after each gain step
// RL3: strength is average over 2..16 filter clocks
// RL4: carrier sense when strength above level plus 8
// RL5: too strong and above minimum: gain down
// RL6: too weak and below maximum: gain up
// RL7: filter clock is twice channel bandwidth
// RL8: threshold field relative to maximum gain field; here threshold is level field plus 8, independent of gmax
// RL9: carrier sense readable in status
// RL10: carrier sense at status bit 3
// RL11: selector 0100 routes carrier sense to pin
// RL12: mode 11 selects automatic power-up sequencing
// RL13: wake, receive, sleep again without carrier
// RL14: sleep bit write enters power-down
// RL15: select pin falling edge wakes when chosen
// RL16: data pin falling edge wakes when chosen
// RL17: receive-wait and carrier-wait fields time sequence
// RL18: calibration always, 16th, 256th or never
// RL19: sequence counter kept until device reset
// RL20: offset read-back signed 8-bit value
// RL21: host computes corrected frequency itself
// RL22: instant frequency read-back signed 8-bit
// RL23: instant frequency updates on demod_config_reg clock
// RL24: selector 1101 routes demod_config_reg clock to pin
// RL25: adc clock is reference over 2(div+1)
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module rxagc_top
   import rxagc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_ce,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // receive datapath
   input  wire logic        i_filter_tick,
   input  wire logic [7:0]  i_magnitude,
   input  wire logic        i_demod_config_reg_tick,
   input  wire logic        i_offset_valid,
   input  wire logic [7:0]  i_freq_offset,
   input  wire logic [7:0]  i_instant_freq,
   input  wire logic        i_cal_done,
   // wake-up pins
   input  wire logic        i_select_pin,
   input  wire logic        i_data_io_pin,
   // control outputs
   output logic             o_rx_power,
   output logic      [4:0]  o_gain,
   output logic             o_cal_req,
   output logic             o_carrier_sense,
   output logic             o_mux_pin
);

   // ****************************************************************
   // bus slave
   // ****************************************************************
   rxagc_req_t  req_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_word;
   wire         acc   = i_ce & i_hsel & i_htrans[1] & i_hready;
   wire  [7:0]  rd_a  = i_haddr[7:0];
   wire         wr_en = i_ce & req_r.valid & req_r.write;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         req_r    <= '0;
         hrdata_r <= 32'h00000000;
      end else if (i_ce) begin
         req_r <= '{addr: rd_a, write: i_hwrite, valid: acc};
         if (acc && !i_hwrite) begin
            hrdata_r <= rd_word;
         end
      end
   end

   assign o_hrdata    = hrdata_r;
   assign o_hreadyout = i_ce;
   assign o_hresp     = 1'b0;

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [6:0] main_r;
   logic [7:0] seq_r;
   logic       split_r;
   logic [4:0] tim_r;
   logic [1:0] avg_r;
   logic [7:0] lim_r;
   logic [8:0] lvl_r;
   logic [2:0] demod_r;
   logic [3:0] mux_r;
   logic [7:0] afc_r;
   logic [7:0] inst_r;

   wire wr_main  = wr_en & (req_r.addr == ADDR_MAIN);
   wire wr_seq   = wr_en & (req_r.addr == ADDR_SEQ);
   wire wr_iface = wr_en & (req_r.addr == ADDR_IFACE);
   wire wr_tim   = wr_en & (req_r.addr == ADDR_TIMING);
   wire wr_avg   = wr_en & (req_r.addr == ADDR_AVG);
   wire wr_lim   = wr_en & (req_r.addr == ADDR_LIMIT);
   wire wr_lvl   = wr_en & (req_r.addr == ADDR_LEVEL);
   wire wr_demod = wr_en & (req_r.addr == ADDR_DEMOD);
   wire wr_mux   = wr_en & (req_r.addr == ADDR_MUX);

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         main_r  <= MAIN_RST;
         seq_r   <= SEQ_RST;
         split_r <= 1'b0;
         tim_r   <= TIM_RST;
         avg_r   <= AVG_RST;
         lim_r   <= LIM_RST;
         lvl_r   <= LVL_RST;
         demod_r <= DEMOD_RST;
         mux_r   <= MUX_RST;
      end else begin
         // sleep bit is a command, never stored
         if (wr_main)  main_r  <= {i_hwdata[6:1], 1'b0};
         if (wr_seq)   seq_r   <= i_hwdata[7:0];
         if (wr_iface) split_r <= i_hwdata[0];
         if (wr_tim)   tim_r   <= i_hwdata[4:0];
         if (wr_avg)   avg_r   <= i_hwdata[1:0];
         if (wr_lim)   lim_r   <= i_hwdata[7:0];
         if (wr_lvl)   lvl_r   <= i_hwdata[8:0];
         if (wr_demod) demod_r <= i_hwdata[2:0];
         if (wr_mux)   mux_r   <= i_hwdata[3:0];
      end
   end

   // named fields; threshold is level field plus 8, independent of maximum gain [RL8]
   wire [1:0] cal_sel  = main_r[MAIN_CAL_LSB +: 2];
   wire [1:0] powerdown_mode_field  = main_r[MAIN_PD_LSB +: 2];
   wire       rx_en    = main_r[MAIN_RXEN_BIT];
   wire [2:0] rxw      = seq_r[SEQ_RXW_LSB +: 3];
   wire [3:0] csw      = seq_r[SEQ_CSW_LSB +: 4];
   wire       wake_sel = seq_r[SEQ_SEL_BIT];
   wire [1:0] frz      = tim_r[TIM_FRZ_LSB +: 2];
   wire [2:0] wsel     = tim_r[TIM_WAIT_LSB +: 3];
   wire [4:0] gmax     = lim_r[LIM_MAX_LSB +: 5];
   wire [2:0] dn_m     = lim_r[LIM_DN_LSB +: 3];
   wire [4:0] cs_lvl   = lvl_r[LVL_CS_LSB +: 5];
   wire [2:0] up_m     = lvl_r[LVL_UP_LSB +: 3];
   wire       cs_set   = lvl_r[LVL_SET_BIT];
   wire       seq_mode = (powerdown_mode_field == PD_SEQUENCE);             // [RL12]

   // ****************************************************************
   // adc clock divider and demod_config_reg clock
   // ****************************************************************
   logic [3:0] adc_cnt_r;
   logic       mclk_r;
   wire  [3:0] adc_last = {demod_r, 1'b1};                    // [RL25]
   wire        adc_tick = i_ce & (adc_cnt_r == adc_last);

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         adc_cnt_r <= 4'h0;
         mclk_r    <= 1'b0;
         afc_r     <= 8'h00;
         inst_r    <= 8'h00;
      end else if (i_ce) begin
         adc_cnt_r <= adc_tick ? 4'h0 : adc_cnt_r + 4'h1;     // [RL25]
         mclk_r    <= i_demod_config_reg_tick;
         if (i_offset_valid) afc_r <= i_freq_offset;          // [RL20]
         if (i_demod_config_reg_tick) inst_r <= i_instant_freq;          // [RL22] [RL23]
      end
   end

   // ****************************************************************
   // gain control loop
   // ****************************************************************
   rxagc_agc_st_t agc_st_r;
   logic [7:0]    agc_cnt_r;
   logic [11:0]   sum_r;
   logic [4:0]    gain_r;
   logic          cs_r;
   logic          rx_on;

   // filter tick arrives at twice the channel bandwidth [RL7]
   wire        ftick     = i_ce & i_filter_tick;
   wire [7:0]  frz_last  = (FREEZE_BASE << frz) - 8'h01;      // [RL1]
   wire [7:0]  set_last  = (wsel == 3'h7) ? SETTLE_MAX - 8'h01
                         : SETTLE_BASE + {3'h0, wsel, 2'h0} - 8'h01;
   wire [7:0]  avg_last  = (AVG_BASE << avg_r) - 8'h01;       // [RL3]
   wire [11:0] sum_nxt   = sum_r + {4'h0, i_magnitude};
   wire [11:0] avg_sh    = sum_nxt >> ({1'b0, avg_r} + 3'h1);
   wire [8:0]  avg_val   = {1'b0, avg_sh[7:0]};
   wire [8:0]  cs_thr    = {4'h0, cs_lvl} + CS_MARGIN;
   wire [8:0]  lo_thr    = cs_thr + {6'h00, up_m};
   wire [8:0]  hi_thr    = lo_thr + {6'h00, dn_m} + DN_HYST;
   wire        meas_done = (agc_st_r == AG_MEAS) & ftick
                         & (agc_cnt_r == avg_last);
   wire        go_dn     = meas_done & (avg_val > hi_thr)
                         & (gain_r != 5'h00);                 // [RL5]
   wire        go_up     = meas_done & ~go_dn & (avg_val < lo_thr)
                         & (gain_r < gmax);                   // [RL6]
   wire        cs_nxt    = ~cs_set & (avg_val > cs_thr);      // [RL4]

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         agc_st_r  <= AG_OFF;
         agc_cnt_r <= 8'h00;
         sum_r     <= 12'h000;
         gain_r    <= 5'h00;
         cs_r      <= 1'b0;
      end else if (i_ce) begin
         if (!rx_on) begin
            agc_st_r  <= AG_OFF;
            agc_cnt_r <= 8'h00;
            gain_r    <= gmax;
            cs_r      <= 1'b0;
         end else begin
            unique case (agc_st_r)
               AG_OFF: begin
                  agc_st_r  <= AG_FREEZE;
                  agc_cnt_r <= 8'h00;
               end
               AG_FREEZE: begin
                  if (adc_tick) begin
                     agc_cnt_r <= agc_cnt_r + 8'h01;
                     if (agc_cnt_r == frz_last) begin         // [RL1]
                        agc_st_r  <= AG_SETTLE;
                        agc_cnt_r <= 8'h00;
                     end
                  end
               end
               AG_SETTLE: begin
                  if (ftick) begin
                     agc_cnt_r <= agc_cnt_r + 8'h01;
                     if (agc_cnt_r == set_last) begin         // [RL2]
                        agc_st_r  <= AG_MEAS;
                        agc_cnt_r <= 8'h00;
                        sum_r     <= 12'h000;
                     end
                  end
               end
               AG_MEAS: begin
                  if (ftick) begin
                     agc_cnt_r <= agc_cnt_r + 8'h01;
                     sum_r     <= sum_nxt;                    // [RL3]
                  end
                  if (meas_done) begin
                     agc_cnt_r <= 8'h00;
                     sum_r     <= 12'h000;
                     cs_r      <= cs_nxt;                     // [RL4]
                     if (go_dn || go_up) begin
                        agc_st_r <= AG_SETTLE;
                     end
                     if (go_dn) gain_r <= gain_r - 5'h01;     // [RL5]
                     if (go_up) gain_r <= gain_r + 5'h01;     // [RL6]
                  end
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // power-up sequencer
   // ****************************************************************
   rxagc_seq_st_t sq_st_r;
   logic [8:0]    sq_cnt_r;
   logic [7:0]    seq_num_r;
   logic          sel_d_r;
   logic          dio_d_r;

   wire       sel_fall = sel_d_r & ~i_select_pin;
   wire       dio_fall = dio_d_r & ~i_data_io_pin;
   wire       wake     = wake_sel ? sel_fall                  // [RL15]
                       : (split_r & dio_fall);                // [RL16]
   wire       sleep_wr = wr_main & seq_mode
                       & i_hwdata[MAIN_SLEEP_BIT];            // [RL14]
   // (field+1)*16 adc ticks, counted from zero
   wire [8:0] rxw_last = {2'b00, rxw, SEQ_UNIT_M1};
   wire [8:0] csw_last = {1'b0, csw, SEQ_UNIT_M1};
   wire       cal_due  = (cal_sel == CAL_ALWAYS)
                       | ((cal_sel == CAL_EVERY16) & (seq_num_r[3:0] == 4'h0))
                       | ((cal_sel == CAL_EVR256) & (seq_num_r == 8'h00));

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         sq_st_r   <= SQ_OFF;
         sq_cnt_r  <= 9'h000;
         seq_num_r <= 8'h00;                                  // [RL19]
         sel_d_r   <= 1'b1;
         dio_d_r   <= 1'b1;
      end else if (i_ce) begin
         sel_d_r <= i_select_pin;
         dio_d_r <= i_data_io_pin;
         if (!seq_mode) begin
            sq_st_r <= SQ_OFF;
         end else if (sleep_wr) begin
            sq_st_r <= SQ_SLEEP;                              // [RL14]
         end else begin
            unique case (sq_st_r)
               SQ_OFF: sq_st_r <= SQ_RX;
               SQ_SLEEP: begin
                  sq_cnt_r <= 9'h000;
                  if (wake) begin                             // [RL13]
                     seq_num_r <= seq_num_r + 8'h01;          // [RL19]
                     sq_st_r   <= cal_due ? SQ_CAL : SQ_RXW;  // [RL18]
                  end
               end
               SQ_CAL: if (i_cal_done) sq_st_r <= SQ_RXW;
               SQ_RXW: begin
                  if (adc_tick) begin
                     sq_cnt_r <= sq_cnt_r + 9'h001;
                     if (sq_cnt_r == rxw_last) begin          // [RL17]
                        sq_st_r  <= SQ_CSW;
                        sq_cnt_r <= 9'h000;
                     end
                  end
               end
               SQ_CSW: begin
                  if (cs_r) begin
                     sq_st_r <= SQ_RX;
                  end else if (adc_tick) begin
                     sq_cnt_r <= sq_cnt_r + 9'h001;
                     if (sq_cnt_r == csw_last) begin          // [RL13] [RL17]
                        sq_st_r <= SQ_SLEEP;
                     end
                  end
               end
               SQ_RX: sq_st_r <= SQ_RX;
            endcase
         end
      end
   end

   assign rx_on = seq_mode ? (sq_st_r == SQ_RXW) | (sq_st_r == SQ_CSW)
                           | (sq_st_r == SQ_RX)
                           : rx_en;

   // ****************************************************************
   // read-back and pins
   // ****************************************************************
   wire        sleeping = (sq_st_r == SQ_SLEEP);
   wire [31:0] stat_w   = {22'h000000, sleeping, gain_r,
                           cs_r, 3'h0};                       // [RL9] [RL10]
   assign rd_word = (rd_a == ADDR_MAIN)   ? {25'h0, main_r[6:1], sleeping}
                  : (rd_a == ADDR_SEQ)    ? {24'h0, seq_r}
                  : (rd_a == ADDR_IFACE)  ? {31'h0, split_r}
                  : (rd_a == ADDR_TIMING) ? {27'h0, tim_r}
                  : (rd_a == ADDR_AVG)    ? {30'h0, avg_r}
                  : (rd_a == ADDR_LIMIT)  ? {24'h0, lim_r}
                  : (rd_a == ADDR_LEVEL)  ? {23'h0, lvl_r}
                  : (rd_a == ADDR_DEMOD)  ? {29'h0, demod_r}
                  : (rd_a == ADDR_MUX)    ? {28'h0, mux_r}
                  : (rd_a == ADDR_STATUS) ? stat_w
                  : (rd_a == ADDR_AFC)    ? {24'h0, afc_r}    // [RL20]
                  : (rd_a == ADDR_INST)   ? {24'h0, inst_r}   // [RL22]
                  : 32'h00000000;

   assign o_mux_pin = (mux_r == MUX_CS)   ? cs_r              // [RL11]
                    : (mux_r == MUX_MCLK) ? mclk_r            // [RL24]
                    : 1'b0;
   assign o_rx_power      = rx_on;
   assign o_gain          = gain_r;
   assign o_cal_req       = (sq_st_r == SQ_CAL);
   assign o_carrier_sense = cs_r;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   AST_CS_SET: assert property (i_ce && rx_on && meas_done   // [RL4]
      && !cs_set && avg_val > cs_thr |=> cs_r)
      else $error("carrier sense not set above threshold");
   AST_GAIN_DN: assert property (i_ce && rx_on && go_dn      // [RL5]
      |=> gain_r == $past(gain_r) - 5'h01 && agc_st_r == AG_SETTLE)
      else $error("gain not lowered one step");
   AST_GAIN_UP: assert property (i_ce && rx_on && go_up      // [RL6]
      |=> gain_r == $past(gain_r) + 5'h01 && gain_r <= gmax)
      else $error("gain not raised one step");
   AST_STAT_CS: assert property (stat_w[STAT_CS_BIT] == cs_r // [RL10]
      && stat_w[STAT_GAIN_LSB +: 5] == gain_r)
      else $error("status bits do not follow state");
   AST_PIN_CS: assert property (mux_r == MUX_CS              // [RL11]
      |-> o_mux_pin == o_carrier_sense)
      else $error("carrier sense not on pin");
   AST_PIN_MCLK: assert property (i_ce && i_demod_config_reg_tick       // [RL24]
      && mux_r == MUX_MCLK && $stable(mux_r) && !wr_mux |=> o_mux_pin)
      else $error("demod_config_reg clock not on pin");
   AST_SLEEP: assert property (i_ce && sleep_wr              // [RL14]
      |=> sq_st_r == SQ_SLEEP && !o_rx_power)
      else $error("sleep write ignored");
   AST_WAKE_SEL: assert property (i_ce && sleeping && wake_sel // [RL15]
      && seq_mode && !sleep_wr && sel_d_r && !i_select_pin
      |=> !sleeping && seq_num_r == $past(seq_num_r) + 8'h01)
      else $error("select pin fall did not wake");
   AST_WAKE_DIO: assert property (i_ce && sleeping && !wake_sel // [RL16]
      && !split_r && seq_mode |=> sleeping || $past(sleep_wr))
      else $error("data pin woke without split pins");
   AST_ADC_DIV: assert property (adc_tick                    // [RL25]
      |=> !adc_tick)
      else $error("adc divider period below two");

endmodule

// [verif/rxagc_host_model.sv]
// rxagc_host_model: host side of the wake-up pins and calibration.
// assumes the wake pins idle high (pulled up) between wake pulses.
`timescale 1ns/100ps
module rxagc_host_model (
   // clock
   input  wire logic i_core_clk,
   // calibration handshake
   input  wire logic i_cal_req,
   output logic      o_cal_done,
   // wake-up pins
   output logic      o_select_pin,
   output logic      o_data_io_pin
);
   int cal_count = 0;
   initial begin
      o_select_pin = 1'b1;
      o_data_io_pin = 1'b1;
      o_cal_done = 1'b0;
   end
   // calibration finishes one cycle after it is requested
   always @(posedge i_core_clk) begin
      o_cal_done <= i_cal_req;
      if (i_cal_req && !o_cal_done) cal_count <= cal_count + 1;
   end
   // falling edge on the chosen pin, then back to idle
   task automatic wake(input logic sel);
      @(posedge i_core_clk);
      if (sel) begin
         o_select_pin <= 1'b0;
      end else begin
         o_data_io_pin <= 1'b0;
      end
      repeat (4) @(posedge i_core_clk);
      o_select_pin <= 1'b1;
      o_data_io_pin <= 1'b1;
   endtask
endmodule

// [verif/tb_top.sv]
// tb_top: register table, gain loop, sequencer and read-back tests.
// assumes a single slave, so hready is the slave's hreadyout.
`timescale 1ns/100ps
module tb_top;
   import rxagc_pkg::*;
   logic clk, rst_n, hw, ft, mt, ov, cal_rq, cal_dn, sel_p, dio_p, ce;
   logic rxp, cs, mx, hrdy, hresp;
   logic [1:0] ht;
   logic [2:0] tc;
   logic [4:0] gain;
   logic [7:0] ha, mag, fo, ifq;
   logic [31:0] hwd, hrd, r;
   int bad_count, comparisons, n;
   logic [7:0] ra [6] = '{8'h14, 8'h00, 8'h20, 8'h10, 8'h0C, 8'h30};
   logic       rw [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   logic [7:0] rd [6] = '{8'h00, 8'h00, 8'h04, 8'h03, 8'hFF, 8'hFF};
   logic [7:0] re [6] = '{8'h0F, 8'h00, 8'h04, 8'h03, 8'h1F, 8'h00};
   rxagc_top dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
      .i_hsel(1'b1), .i_haddr({24'h000000, ha}), .i_htrans(ht),
      .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy),
      .o_hrdata(hrd), .o_hreadyout(hrdy), .o_hresp(hresp),
      .i_filter_tick(ft), .i_magnitude(mag), .i_demod_config_reg_tick(mt),
      .i_offset_valid(ov), .i_freq_offset(fo), .i_instant_freq(ifq),
      .i_cal_done(cal_dn), .i_select_pin(sel_p), .i_data_io_pin(dio_p),
      .o_rx_power(rxp), .o_gain(gain), .o_cal_req(cal_rq),
      .o_carrier_sense(cs), .o_mux_pin(mx));
   rxagc_host_model host (.i_core_clk(clk), .i_cal_req(cal_rq),
      .o_cal_done(cal_dn), .o_select_pin(sel_p), .o_data_io_pin(dio_p));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // filter tick every 4 cycles, demod_config_reg tick every 8
   always @(posedge clk) begin
      tc <= tc + 3'h1;
      ft <= (tc[1:0] == 2'h3);
      mt <= (tc == 3'h7);
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h saw %h", nm, e, s);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic tmo();
      if (n >= 5000) begin
         bad_count++;
         results();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int k;
      ht <= 2'h2;
      ha <= a;
      hw <= w;
      @(posedge clk);
      for (k = 0; k < 50 && hrdy !== 1'b1; k++) @(posedge clk);
      if (k >= 50) n = 5000;
      ht <= 2'h0;
      hwd <= d;
      @(posedge clk);
      for (k = 0; k < 50 && hrdy !== 1'b1; k++) @(posedge clk);
      r = hrd;
      if (k >= 50) n = 5000;
      tmo();
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst_n, hw, tc, ov, ht, ha, hwd, mag, fo, ft, mt} = '0;
      {ce, ifq} = {1'b1, 8'hA5};
      repeat (4) @(posedge clk);
      chk("gain", gain, 5'h00);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk("resp", hresp, 1'b0);
      chk("gmax", gain, 5'h0F);
      for (int i = 0; i < 6; i++) begin
         if (rw[i]) bus(ra[i], 1'b1, {24'h000000, rd[i]});
         bus(ra[i], 1'b0, 32'h00000000);
         chk("reg", r, {24'h000000, re[i]});
      end
      $display("done registers");
      bus(ADDR_TIMING, 1'b1, 32'h00000000);
      bus(ADDR_AVG, 1'b1, 32'h00000000);
      bus(ADDR_MUX, 1'b1, 32'h00000004);
      mag <= 8'hFF;
      bus(ADDR_MAIN, 1'b1, 32'h00000040);
      repeat (90) @(posedge clk);
      chk("frz", gain, 5'h0F);
      for (n = 0; n < 5000 && gain !== 5'h00; n++) @(posedge clk);
      tmo();
      chk("cs", cs, 1'b1);
      chk("pin", mx, 1'b1);
      bus(ADDR_STATUS, 1'b0, 32'h00000000);
      chk("stat", r, 32'h00000008);
      bus(ADDR_LEVEL, 1'b1, 32'h00000100);
      for (n = 0; n < 5000 && cs !== 1'b0; n++) @(posedge clk);
      tmo();
      mag <= 8'h00;
      bus(ADDR_LIMIT, 1'b1, 32'h00000008);
      for (n = 0; n < 5000 && gain !== 5'h08; n++) @(posedge clk);
      tmo();
      repeat (300) @(posedge clk);
      chk("max", gain, 5'h08);
      $display("done gain loop");
      bus(ADDR_MAIN, 1'b1, 32'h00000030);
      bus(ADDR_SEQ, 1'b1, 32'h00000080);
      bus(ADDR_MAIN, 1'b1, 32'h00000031);
      @(posedge clk);
      chk("rxoff", rxp, 1'b0);
      bus(ADDR_STATUS, 1'b0, 32'h00000000);
      chk("slp", r & 32'h00000200, 32'h00000200);
      host.wake(1'b1);
      for (n = 0; n < 5000 && host.cal_count != 1; n++) @(posedge clk);
      tmo();
      for (n = 0; n < 5000 && rxp !== 1'b1; n++) @(posedge clk);
      tmo();
      for (n = 0; n < 5000 && rxp !== 1'b0; n++) @(posedge clk);
      tmo();
      bus(ADDR_SEQ, 1'b1, 32'h00000000);
      bus(ADDR_IFACE, 1'b1, 32'h00000001);
      host.wake(1'b0);
      for (n = 0; n < 5000 && rxp !== 1'b1; n++) @(posedge clk);
      tmo();
      chk("cal", host.cal_count, 2);
      $display("done sequencer");
      fo <= 8'h9C;
      ov <= 1'b1;
      @(posedge clk);
      ov <= 1'b0;
      bus(ADDR_AFC, 1'b0, 32'h00000000);
      chk("afc", r, 32'h0000009C);
      bus(ADDR_INST, 1'b0, 32'h00000000);
      chk("inst", r, 32'h000000A5);
      bus(ADDR_MUX, 1'b1, 32'h0000000D);
      for (n = 0; n < 50 && mx !== 1'b1; n++) @(posedge clk);
      chk("mclk", mx, 1'b1);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      chk("ce_rdy", hrdy, 1'b0);
      chk("ce_mx", mx, 1'b0);
      ce <= 1'b1;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk("rst_gain", gain, 5'h0F);
      bus(ADDR_MUX, 1'b0, 32'h00000000);
      chk("rst_mux", r, 32'h00000000);
      $display("done read-back");
      results();
   end
endmodule
